/* cfg_host_model.sv */
// host model driving the configuration request pin
// assumes the device acknowledges on status_ack_n
`timescale 1ns/1ns
module cfg_host_model (
  input wire logic clk,
  input wire logic status_ack_n,
  output logic config_request_n
);
  // always driven, never floating; held high until the first drive
  initial config_request_n = 1'b1;
  // the request moves only while it matches the acknowledge; the wait is bounded
  // at 64 cycles, far short of an error pulse, after which the request is left unchanged
  task automatic drive(input logic lvl, input int gap);
    int n;
    n = 0;
    while (status_ack_n !== config_request_n && n < 64) begin
      @(negedge clk);
      n++;
    end
    repeat (gap) @(negedge clk);
    if (status_ack_n === config_request_n) begin
      config_request_n = lvl;
    end
  endtask
endmodule

/* config_pin_handshake.sv */
// configuration request / acknowledge pin handshake of the device manager
// assumes pin inputs are asynchronous; internal status inputs share clk
//
// Function
// - a rising request input starts configuration or reconfiguration
// - acknowledge follows the request level except during errors
// - request falling mid-cycle abandons the cycle, waits for a new one
// - after power-on, acknowledge goes low only once request goes low
// - an error pulses acknowledge low 0.5 to 1.5 ms by failure type
// - error pulse is not timed to the internal detection instant
// - no restart after an error until the host requests again
// - partial reconfiguration failures never pull acknowledge low
// - load complete and user mode stay low before and during loading
// - load complete rises once all configuration data is received
// - user mode output rises on entering user mode, after load complete
// - application reset is held until the whole fabric reports user mode
// - load complete and user mode pins may be given other functions
// - seventeen manager pins whose functions the bitstream assigns
// - fabric loads only after firmware checks; firmware section first
`timescale 1ns/1ns
`include "config_pin_handshake_regs.svh"

module config_pin_handshake (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_request_n,
  input wire logic firmware_checks_ok,
  input wire logic section_done,
  input wire logic [1:0] section_id,
  input wire logic config_error,
  input wire logic error_long,
  input wire logic partial_reconfig_error,
  input wire logic data_ready,
  input wire logic fabric_user_mode,
  input wire logic pin_fn_valid,
  input wire logic [`MGR_IO_COUNT*`PIN_FN_WIDTH-1:0] pin_fn,
  input wire logic [`MGR_IO_COUNT-1:0] gpio_out,
  output logic status_ack_n,
  output logic load_complete,
  output logic user_mode,
  output logic stream_ready,
  output logic app_reset_n,
  output logic config_active,
  output logic [`MGR_IO_COUNT-1:0] manager_io_pin_out,
  output logic [`MGR_IO_COUNT-1:0] manager_io_pin_oe_n
);
  localparam logic [`CNT_WIDTH-1:0] ERR_SHORT =
    `CNT_WIDTH'(`ERR_PULSE_MIN_CYC);
  localparam logic [`CNT_WIDTH-1:0] ERR_LONG =
    `CNT_WIDTH'(`ERR_PULSE_MAX_CYC);

  logic rst_s1_reg, rst_sync_n;
  logic req_s1_reg, req_s2_reg, req_s3_reg;
  logic req_reg, req_prev_reg;
  logic req_rise, req_fall;
  config_pin_handshake_pkg::cfg_state_t state_reg, state_next;
  config_pin_handshake_pkg::section_t expect_sec_reg;
  logic [`CNT_WIDTH-1:0] err_cnt_reg;
  logic err_pending_reg, err_len_reg;
  logic [`PIN_FN_WIDTH-1:0] fn_reg [`MGR_IO_COUNT];
  logic in_cycle;

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  // request pin: three stages, a change counts once stages two and three agree
  // reset high so a request held high gives no false edge after reset
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_s1_reg <= 1'b1;
      req_s2_reg <= 1'b1;
      req_s3_reg <= 1'b1;
      req_reg <= 1'b1;
      req_prev_reg <= 1'b1;
    end else begin
      req_s1_reg <= config_request_n;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      if (req_s2_reg == req_s3_reg) begin
        req_reg <= req_s3_reg;
      end
      req_prev_reg <= req_reg;
    end
  end

  assign req_rise = req_reg && !req_prev_reg;
  assign req_fall = !req_reg && req_prev_reg;
  assign in_cycle = (state_reg == config_pin_handshake_pkg::ST_FIRMWARE) ||
                    (state_reg == config_pin_handshake_pkg::ST_LOADING) ||
                    (state_reg == config_pin_handshake_pkg::ST_INIT);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      config_pin_handshake_pkg::ST_POR: begin
        if (!req_reg) begin
          state_next = config_pin_handshake_pkg::ST_IDLE_LOW;
        end
      end
      config_pin_handshake_pkg::ST_IDLE_LOW: begin
        if (req_rise) begin
          state_next = config_pin_handshake_pkg::ST_FIRMWARE;
        end
      end
      config_pin_handshake_pkg::ST_FIRMWARE: begin
        if (firmware_checks_ok) begin
          state_next = config_pin_handshake_pkg::ST_LOADING;
        end
      end
      config_pin_handshake_pkg::ST_LOADING: begin
        if (section_done && section_id == 2'(`SECTION_COUNT - 1) &&
            expect_sec_reg == config_pin_handshake_pkg::SEC_FABRIC) begin
          state_next = config_pin_handshake_pkg::ST_INIT;
        end
      end
      config_pin_handshake_pkg::ST_INIT: begin
        if (fabric_user_mode) begin
          state_next = config_pin_handshake_pkg::ST_USER;
        end
      end
      config_pin_handshake_pkg::ST_USER: begin
        if (req_fall) begin
          state_next = config_pin_handshake_pkg::ST_IDLE_LOW;
        end
      end
      config_pin_handshake_pkg::ST_ERROR: begin
        if (err_cnt_reg == '0) begin
          state_next = config_pin_handshake_pkg::ST_WAIT_CLEAR;
        end
      end
      config_pin_handshake_pkg::ST_WAIT_CLEAR: begin
        // no restart of its own: the host drops the request first
        if (!req_reg) begin
          state_next = config_pin_handshake_pkg::ST_IDLE_LOW;
        end
      end
      default: state_next = config_pin_handshake_pkg::ST_POR;
    endcase
    // an error, or a sequence fault, ends the cycle with a pulse
    if (in_cycle && req_reg && (err_pending_reg ||
        (section_done && section_id != expect_sec_reg))) begin
      state_next = config_pin_handshake_pkg::ST_ERROR;
    end
    if (in_cycle && req_fall) begin
      state_next = config_pin_handshake_pkg::ST_IDLE_LOW;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= config_pin_handshake_pkg::ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // error is latched and reported on the next state step, so the pulse
  // start is decoupled from the detection cycle
  // a failure flagged as partial reconfiguration never starts a pulse
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      err_pending_reg <= 1'b0;
      err_len_reg <= 1'b0;
    end else if (in_cycle && config_error && !partial_reconfig_error) begin
      err_pending_reg <= 1'b1;
      err_len_reg <= error_long;
    end else if (!in_cycle) begin
      err_pending_reg <= 1'b0;
    end
  end

  // pulse length is picked by the failure type latched with the error
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      err_cnt_reg <= '0;
    end else if (state_next == config_pin_handshake_pkg::ST_ERROR &&
                 state_reg != config_pin_handshake_pkg::ST_ERROR) begin
      err_cnt_reg <= err_len_reg ? ERR_LONG - 1'b1 : ERR_SHORT - 1'b1;
    end else if (err_cnt_reg != '0) begin
      err_cnt_reg <= err_cnt_reg - 1'b1;
    end
  end

  // section order: firmware, io, boot, fabric
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      expect_sec_reg <= config_pin_handshake_pkg::SEC_FIRMWARE;
    end else if (!in_cycle) begin
      expect_sec_reg <= config_pin_handshake_pkg::SEC_FIRMWARE;
    end else if (section_done && section_id == expect_sec_reg &&
                 expect_sec_reg != config_pin_handshake_pkg::SEC_FABRIC) begin
      expect_sec_reg <=
        config_pin_handshake_pkg::section_t'(expect_sec_reg + 2'h1);
    end
  end

  // acknowledge: high after power-on until request first goes low
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_ack_n <= 1'b1;
    end else begin
      case (state_next)
        config_pin_handshake_pkg::ST_POR: status_ack_n <= 1'b1;
        // once the pulse ends ack follows the request, so the host may drop it
        config_pin_handshake_pkg::ST_ERROR: status_ack_n <= 1'b0;
        default: status_ack_n <= req_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      load_complete <= 1'b0;
    end else begin
      load_complete <=
        state_next inside {config_pin_handshake_pkg::ST_INIT,
                           config_pin_handshake_pkg::ST_USER};
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      user_mode <= 1'b0;
    end else begin
      user_mode <= state_next == config_pin_handshake_pkg::ST_USER;
    end
  end

  // application logic stays in reset until the whole fabric is up
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      app_reset_n <= 1'b0;
    end else begin
      app_reset_n <= state_next == config_pin_handshake_pkg::ST_USER;
    end
  end

  // ready only while loading; the host also waits for the acknowledge
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stream_ready <= 1'b0;
    end else begin
      stream_ready <= state_next == config_pin_handshake_pkg::ST_LOADING &&
                      data_ready;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      config_active <= 1'b0;
    end else begin
      config_active <= in_cycle;
    end
  end

  // manager pin functions, latched from the bitstream io section
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < `MGR_IO_COUNT; i++) begin
        fn_reg[i] <= `FN_GPIO;
      end
    end else if (pin_fn_valid && in_cycle) begin
      for (int i = 0; i < `MGR_IO_COUNT; i++) begin
        fn_reg[i] <= pin_fn[i*`PIN_FN_WIDTH +: `PIN_FN_WIDTH];
      end
    end
  end

  // unassigned pins stay released until user mode, then drive gpio_out
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      manager_io_pin_out <= '0;
      manager_io_pin_oe_n <= '1;
    end else begin
      for (int i = 0; i < `MGR_IO_COUNT; i++) begin
        case (fn_reg[i])
          `FN_LOAD_COMPLETE: begin
            manager_io_pin_out[i] <= load_complete;
            manager_io_pin_oe_n[i] <= 1'b0;
          end
          `FN_USER_MODE: begin
            manager_io_pin_out[i] <= user_mode;
            manager_io_pin_oe_n[i] <= 1'b0;
          end
          default: begin
            manager_io_pin_out[i] <= gpio_out[i];
            manager_io_pin_oe_n[i] <= !user_mode;
          end
        endcase
      end
    end
  end
endmodule

/* config_pin_handshake_asserts.sv */
// checker for the pin handshake, bound to the top module ports
// assumes the header macros and one clock domain
`timescale 1ns/1ns
`include "config_pin_handshake_regs.svh"
module config_pin_handshake_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_request_n,
  input wire logic config_error,
  input wire logic partial_reconfig_error,
  input wire logic section_done,
  input wire logic [1:0] section_id,
  input wire logic status_ack_n,
  input wire logic load_complete,
  input wire logic user_mode,
  input wire logic app_reset_n,
  input wire logic config_active
);
  logic seen_low_reg;
  logic [`CNT_WIDTH-1:0] err_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) seen_low_reg <= 1'b0;
    else if (!config_request_n) seen_low_reg <= 1'b1;
  end
  // counter stops at the minimum, so it stays small and cheap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) err_cnt_reg <= '0;
    else if (!config_request_n) err_cnt_reg <= '0;
    else if (config_error && !partial_reconfig_error && config_active)
      err_cnt_reg <= 20'h0_0001;
    else if (err_cnt_reg != '0 && err_cnt_reg < `ERR_PULSE_MIN_CYC)
      err_cnt_reg <= err_cnt_reg + 1'b1;
  end
  property p_req_rise;
    $rose(config_request_n) && !status_ack_n |-> ##[1:8] status_ack_n;
  endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("ack did not follow rising request");
  property p_req_fall;
    $fell(config_request_n) |-> ##[1:8] !status_ack_n;
  endproperty
  a_req_fall: assert property (p_req_fall)
    else $error("ack did not follow falling request");
  property p_abort;
    $fell(config_request_n) |-> ##[1:8] (!config_active && !load_complete);
  endproperty
  a_abort: assert property (p_abort)
    else $error("cycle not abandoned");
  property p_por;
    !seen_low_reg |-> status_ack_n;
  endproperty
  a_por: assert property (p_por)
    else $error("ack low before request seen low");
  property p_err;
    config_error && !partial_reconfig_error && config_active
      |-> ##[1:4] !status_ack_n;
  endproperty
  a_err: assert property (p_err)
    else $error("error pulse missing");
  property p_err_hold;
    err_cnt_reg > 20'h0_0004 && err_cnt_reg < `ERR_PULSE_MIN_CYC
      |-> !status_ack_n;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error pulse too short");
  property p_pr;
    partial_reconfig_error && status_ack_n && config_request_n &&
      !$past(config_error) && !section_done |=> status_ack_n [*2];
  endproperty
  a_pr: assert property (p_pr)
    else $error("partial failure pulled ack low");
  property p_lc;
    section_done && section_id == 2'h3 && config_active
      |-> ##[1:2] load_complete;
  endproperty
  a_lc: assert property (p_lc)
    else $error("load complete late");
  property p_um;
    user_mode |-> load_complete;
  endproperty
  a_um: assert property (p_um)
    else $error("user mode before load complete");
  property p_app;
    app_reset_n |-> user_mode;
  endproperty
  a_app: assert property (p_app)
    else $error("application reset released early");
endmodule
bind config_pin_handshake config_pin_handshake_chk chk (.clk, .rst_n,
  .config_request_n, .config_error, .partial_reconfig_error, .section_done,
  .section_id, .status_ack_n, .load_complete, .user_mode, .app_reset_n,
  .config_active);

/* config_pin_handshake_pkg.sv */
// types for the configuration pin handshake block
// assumes config_pin_handshake_regs.svh is on the include path
`include "config_pin_handshake_regs.svh"

package config_pin_handshake_pkg;
  typedef enum logic [2:0] {
    ST_POR,
    ST_IDLE_LOW,
    ST_FIRMWARE,
    ST_LOADING,
    ST_INIT,
    ST_USER,
    ST_ERROR,
    ST_WAIT_CLEAR
  } cfg_state_t;

  typedef enum logic [1:0] {
    SEC_FIRMWARE,
    SEC_IO,
    SEC_BOOT,
    SEC_FABRIC
  } section_t;
endpackage

/* config_pin_handshake_regs.svh */
// constants for the configuration pin handshake block
// assumes a 250 MHz clock; included by the package and the design
`ifndef CONFIG_PIN_HANDSHAKE_REGS_SVH
`define CONFIG_PIN_HANDSHAKE_REGS_SVH

`define CLK_PERIOD_PS 4000
`define ERR_PULSE_MIN_US 500
`define ERR_PULSE_MAX_US 1500
`define ERR_PULSE_MIN_CYC ((`ERR_PULSE_MIN_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ERR_PULSE_MAX_CYC ((`ERR_PULSE_MAX_US * 1000000) / `CLK_PERIOD_PS)
`define MGR_IO_COUNT 17
`define PIN_FN_WIDTH 3
`define CNT_WIDTH 20
`define FN_LOAD_COMPLETE 3'h1
`define FN_USER_MODE 3'h2
`define FN_GPIO 3'h0
`define SECTION_COUNT 4

`endif

/* testbench.sv */
// self-checking bench for the pin handshake block
// assumes the host model and checker are compiled first
`timescale 1ns/1ns
`include "config_pin_handshake_regs.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic firmware_checks_ok = 1'b0, section_done = 1'b0, config_error = 1'b0;
  logic [1:0] section_id = 2'h0;
  logic error_long = 1'b0, partial_reconfig_error = 1'b0, data_ready = 1'b0;
  logic fabric_user_mode = 1'b0, pin_fn_valid = 1'b0;
  logic [50:0] pin_fn = '0;
  logic [16:0] gpio_out = 17'h0_0000;
  logic config_request_n, status_ack_n, load_complete, user_mode;
  logic stream_ready, app_reset_n, config_active;
  logic [16:0] manager_io_pin_out, manager_io_pin_oe_n;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  cfg_host_model host (.clk, .status_ack_n, .config_request_n);
  config_pin_handshake dut (.clk, .rst_n, .config_request_n,
    .firmware_checks_ok, .section_done, .section_id, .config_error,
    .error_long, .partial_reconfig_error, .data_ready, .fabric_user_mode,
    .pin_fn_valid, .pin_fn, .gpio_out, .status_ack_n, .load_complete,
    .user_mode, .stream_ready, .app_reset_n, .config_active,
    .manager_io_pin_out, .manager_io_pin_oe_n);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait; the caller judges the level reached
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (status_ack_n !== lvl && n < 20) begin
      step(1);
      n++;
    end
  endtask
  task automatic section(input logic [1:0] id);
    section_id = id;
    section_done = 1'b1;
    step(1);
    section_done = 1'b0;
    step(3);
  endtask
  task automatic t_por;
    step(20);
    check(status_ack_n, 1'h1);
    host.drive(1'b0, 0);
    wait_ack(1'b0);
    check(status_ack_n, 1'h0);
  endtask
  task automatic t_config;
    host.drive(1'b1, 3);
    wait_ack(1'b1);
    check(status_ack_n, 1'h1);
    step(2);
    check({config_active, user_mode, load_complete}, 3'h4);
    data_ready = 1'b1;
    firmware_checks_ok = 1'b1;
    step(4);
    check(stream_ready, 1'h1);
    // pin functions arrive while loading, before the first section completes
    pin_fn[17:15] = `FN_LOAD_COMPLETE;
    gpio_out = 17'h0_0001;
    pin_fn_valid = 1'b1;
    step(1);
    pin_fn_valid = 1'b0;
    step(3);
    check({manager_io_pin_oe_n[5], manager_io_pin_out[5],
           manager_io_pin_oe_n[0]}, 3'h1);
    for (logic [2:0] i = 0; i < 4; i++) section(i[1:0]);
    check({user_mode, load_complete}, 2'h1);
    fabric_user_mode = 1'b1;
    step(3);
    check({app_reset_n, user_mode}, 2'h3);
    check(manager_io_pin_out[5], 1'h1);
    check({manager_io_pin_oe_n[5], manager_io_pin_out[0]}, 2'h1);
  endtask
  task automatic t_abort;
    host.drive(1'b0, 0);
    fabric_user_mode = 1'b0;
    wait_ack(1'b0);
    check({user_mode, load_complete}, 2'h0);
    host.drive(1'b1, 0);
    wait_ack(1'b1);
    step(4);
    section(2'h0);
    section(2'h1);
    host.drive(1'b0, 0);
    wait_ack(1'b0);
    step(2);
    check({status_ack_n, config_active}, 2'h0);
    section(2'h2);
    section(2'h3);
    check(load_complete, 1'h0);
  endtask
  task automatic t_error;
    host.drive(1'b1, 0);
    wait_ack(1'b1);
    step(6);
    partial_reconfig_error = 1'b1;
    config_error = 1'b1;
    step(1);
    partial_reconfig_error = 1'b0;
    config_error = 1'b0;
    step(4);
    check(status_ack_n, 1'h1);
    config_error = 1'b1;
    step(1);
    config_error = 1'b0;
    step(5);
    check(status_ack_n, 1'h0);
    step(2000);
    check({status_ack_n, load_complete, config_active}, 3'h0);
    // the pulse outlasts the run, so a reset ends it
    rst_n = 1'b0;
    step(4);
    check(status_ack_n, 1'h1);
    rst_n = 1'b1;
    step(8);
    check({status_ack_n, config_active}, 2'h2);
    host.drive(1'b0, 0);
    wait_ack(1'b0);
    check(status_ack_n, 1'h0);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    step(8);
    t_por();
    t_config();
    t_abort();
    t_error();
    print_verdict();
  end
endmodule
